// [common/bwdt_pkg.sv]
// Purpose: shared constants for the board watchdog timer
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes:   time-out held as an 8-bit unit count, zero disables
package bwdt_pkg;

   // count width and the disabling value
   localparam int          CNT_W          = 8;
   localparam logic [7:0]  CNT_OFF        = 8'h00;
   localparam logic [7:0]  CNT_LAST       = 8'h01;

   // clock and unit timing
   localparam longint      CLK_PERIOD_PS  = 64'd4000;
   localparam longint      SEC_PS         = 64'd1000000000000;
   localparam longint      SEC_CYCLES     = SEC_PS / CLK_PERIOD_PS;
   localparam int          SECS_PER_MIN   = 60;

   // length of the cold reset strobe
   localparam longint      RST_PULSE_NS   = 64'd64;
   localparam longint      RST_CYCLES_L   = (RST_PULSE_NS * 64'd1000 + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
   localparam logic [7:0]  RST_CYCLES     = RST_CYCLES_L[7:0];

   // unit select encodings
   localparam logic        UNIT_SEC       = 1'b0;
   localparam logic        UNIT_MIN       = 1'b1;

   // expiry action encodings
   localparam logic        ACT_RESET      = 1'b0;
   localparam logic        ACT_NMI        = 1'b1;

   // controller states, gray along idle, run, fire
   typedef enum logic [1:0]
   {
      BWDT_IDLE = 2'b00,
      BWDT_RUN  = 2'b01,
      BWDT_FIRE = 2'b11
   } bwdt_state_t;

endpackage : bwdt_pkg

// [common/bwdt_tick_if.sv]
// Purpose: link between the watchdog controller and its unit tick source
// Assumes: single clock domain
// Notes:   restart realigns the tick so a fresh load gets a full first unit
`timescale 1ns/1ps
interface bwdt_tick_if;
   logic restart;
   logic unit_min;
   logic tick;

   modport ctrl
   (
      output restart,
      output unit_min,
      input  tick
   );

   modport gen
   (
      input  restart,
      input  unit_min,
      output tick
   );
endinterface : bwdt_tick_if

// [src/bwdt_tick.sv]
// Purpose: one-cycle tick at the end of every watchdog time unit
// Assumes: clock rate fixed by SEC_CYCLES
// Notes:   unit is one second or one minute, chosen by unit_min
`timescale 1ns/1ps
module bwdt_tick #(
   parameter longint SEC_CYCLES   = bwdt_pkg::SEC_CYCLES,
   parameter int     SECS_PER_MIN = bwdt_pkg::SECS_PER_MIN
)(
   input  wire logic clk,
   input  wire logic sys_rst,
   bwdt_tick_if.gen  tk
);
   localparam int PRE_W = $clog2(SEC_CYCLES + 1);
   localparam int SEC_W = $clog2(SECS_PER_MIN + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SEC_CYCLES - 1);
   localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SECS_PER_MIN - 1);

   logic [PRE_W-1:0] pre;
   logic [SEC_W-1:0] secs;
   logic             sec_end;

   assign sec_end = (pre == PRE_LAST);

   // cycle prescaler down to one second
   always_ff @(posedge clk)
   begin
      if (sys_rst || tk.restart || sec_end)
         pre <= '0;
      else
         pre <= pre + PRE_W'(1);
   end

   // seconds within a minute
   always_ff @(posedge clk)
   begin
      if (sys_rst || tk.restart)
         secs <= '0;
      else if (sec_end)
         secs <= (secs == SEC_LAST) ? '0 : secs + SEC_W'(1);
   end

   // unit tick, registered
   always_ff @(posedge clk)
   begin
      if (sys_rst || tk.restart)
         tk.tick <= 1'b0;
      else
         tk.tick <= sec_end && ((tk.unit_min == bwdt_pkg::UNIT_SEC) || (secs == SEC_LAST));
   end
endmodule : bwdt_tick

// [src/bwdt_top.sv]
// Purpose: system watchdog with an 8-bit unit count and reset or nmi action
// Assumes: load strobe and settings synchronous to clk
// Notes:   settings stand in for setup options, no software registers
//
// What this block does
// - on expiry the block drives a cold reset strobe or an nmi pulse, chosen by act_nmi.
// - a nonzero load starts counting down from that value, one step per time unit.
// - when the count reaches zero the expiry action is fired.
// - loading zero stops the watchdog and no action follows.
// - the step length comes from the unit select input, not from the loaded value.
`timescale 1ns/1ps
module bwdt_top #(
   parameter longint     SEC_CYCLES   = bwdt_pkg::SEC_CYCLES,
   parameter int         SECS_PER_MIN = bwdt_pkg::SECS_PER_MIN,
   parameter logic [7:0] RST_CYCLES   = bwdt_pkg::RST_CYCLES
)(
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      load_valid,
   input  wire logic [bwdt_pkg::CNT_W-1:0] load_value,
   input  wire logic                      unit_min,
   input  wire logic                      act_nmi,
   output logic                           cold_rst,
   output logic                           nmi,
   output logic                           active,
   output logic                           expired,
   output logic [bwdt_pkg::CNT_W-1:0]     count
);

   bwdt_pkg::bwdt_state_t state;
   bwdt_pkg::bwdt_state_t next_state;

   bwdt_tick_if tick_link ();

   logic       load_nz;
   logic       load_zero;
   logic       step;
   logic       last_step;
   logic       fire_done;
   logic       act_latch;
   logic [7:0] pulse_cnt;

   // unit tick source, realigned on every accepted load
   bwdt_tick #(
      .SEC_CYCLES   (SEC_CYCLES),
      .SECS_PER_MIN (SECS_PER_MIN)
   ) u_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tk      (tick_link)
   );

   // unit select passes straight to the tick source
   assign tick_link.unit_min = unit_min;

   // a load counts unless the fire phase is running
   function automatic logic bwdt_take(input logic valid, input bwdt_pkg::bwdt_state_t st);
      bwdt_take = valid && (st != bwdt_pkg::BWDT_FIRE);
   endfunction : bwdt_take

   // loads are ignored while the reset strobe is out
   assign load_nz   = bwdt_take(load_valid, state) && (load_value != bwdt_pkg::CNT_OFF);
   assign load_zero = bwdt_take(load_valid, state) && (load_value == bwdt_pkg::CNT_OFF);
   assign tick_link.restart = load_nz || load_zero;

   // one count step per unit while running
   assign step      = (state == bwdt_pkg::BWDT_RUN) && tick_link.tick && !load_valid;
   assign last_step = step && (count == bwdt_pkg::CNT_LAST);

   // end of the fire phase: nmi is one cycle, reset is a timed strobe
   assign fire_done = (act_latch == bwdt_pkg::ACT_NMI) || (pulse_cnt == RST_CYCLES);

   // next state
   always_comb
   begin
      next_state = state;
      unique case (state)
         bwdt_pkg::BWDT_IDLE:
         begin
            if (load_nz)
               next_state = bwdt_pkg::BWDT_RUN;
         end
         bwdt_pkg::BWDT_RUN:
         begin
            if (load_zero)
               next_state = bwdt_pkg::BWDT_IDLE;
            else if (last_step)
               next_state = bwdt_pkg::BWDT_FIRE;
         end
         bwdt_pkg::BWDT_FIRE:
         begin
            if (fire_done)
               next_state = bwdt_pkg::BWDT_IDLE;
         end
         default:
            next_state = bwdt_pkg::BWDT_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state <= bwdt_pkg::BWDT_IDLE;
      else
         state <= next_state;
   end

   // time-out counter, 8 bits, reloaded on every accepted load
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         count <= bwdt_pkg::CNT_OFF;
      else if (load_nz || load_zero)
         count <= load_value;
      else if (step)
         count <= count - 8'h01;
   end

   // action choice frozen at the moment of expiry
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         act_latch <= bwdt_pkg::ACT_RESET;
      else if (last_step)
         act_latch <= act_nmi;
   end

   // strobe length counter during the fire phase
   always_ff @(posedge clk)
   begin
      if (sys_rst || state != bwdt_pkg::BWDT_FIRE)
         pulse_cnt <= 8'h01;
      else
         pulse_cnt <= pulse_cnt + 8'h01;
   end

   // cold reset strobe
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cold_rst <= 1'b0;
      else if (last_step)
         cold_rst <= (act_nmi == bwdt_pkg::ACT_RESET);
      else if (state == bwdt_pkg::BWDT_FIRE && fire_done)
         cold_rst <= 1'b0;
   end

   // nmi pulse, one cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         nmi <= 1'b0;
      else
         nmi <= last_step && (act_nmi == bwdt_pkg::ACT_NMI);
   end

   // running flag
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         active <= 1'b0;
      else
         active <= (next_state == bwdt_pkg::BWDT_RUN);
   end

   // sticky expiry flag, set wins over the clear by a load
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         expired <= 1'b0;
      else if (last_step)
         expired <= 1'b1;
      else if (load_nz || load_zero)
         expired <= 1'b0;
   end

endmodule : bwdt_top

// [dv/bwdt_assertions.sv]
// Purpose: port checks for the board watchdog
// Assumes: one clock, sys_rst synchronous active high
// Notes:   bound to bwdt_top
`timescale 1ns/1ps
module bwdt_assertions #(
   parameter logic [7:0] RST_CYCLES = 8'h10
)(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       load_valid,
   input wire logic [7:0] load_value,
   input wire logic       act_nmi,
   input wire logic       cold_rst,
   input wire logic       nmi,
   input wire logic       active,
   input wire logic       expired,
   input wire logic [7:0] count
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic [7:0] rst_run;
   // length of the running cold reset strobe
   always_ff @(posedge clk)
   begin
      rst_run <= cold_rst ? rst_run + 8'h01 : 8'h00;
   end
   // countdown ran out without a load
   sequence s_expire;
      $fell(active) && !$past(load_valid);
   endsequence
   // a load is taken outside the fire phase, shown by the strobe or the nmi pulse
   sequence s_take;
      load_valid && !cold_rst && !nmi;
   endsequence
   property p_load;
      s_take |=> count == $past(load_value) && active == ($past(load_value) != 8'h00);
   endproperty
   property p_fire;
      s_expire |-> expired && (cold_rst != nmi);
   endproperty
   property p_step;
      active && $past(active) && !$past(load_valid) |-> count == $past(count) || count == $past(count) - 8'h01;
   endproperty
   property p_zero;
      s_take and (load_value == 8'h00) |=> (!active && !cold_rst && !nmi)[*8];
   endproperty
   property p_rstlen;
      $fell(cold_rst) |-> rst_run == RST_CYCLES;
   endproperty
   property p_nmi;
      nmi |-> expired ##1 !nmi;
   endproperty
   property p_act;
      $rose(expired) |-> nmi == $past(act_nmi) && cold_rst == !$past(act_nmi);
   endproperty
   property p_idle;
      !active && !load_valid |=> !active;
   endproperty
   a_load: assert property (p_load) else $error("load not taken");
   a_fire: assert property (p_fire) else $error("no action at expiry");
   a_step: assert property (p_step) else $error("count jumped");
   a_zero: assert property (p_zero) else $error("zero load did not disable");
   a_rstlen: assert property (p_rstlen) else $error("reset strobe length wrong");
   a_nmi: assert property (p_nmi) else $error("nmi not a single pulse");
   a_act: assert property (p_act) else $error("wrong expiry action");
   a_idle: assert property (p_idle) else $error("started without load");
endmodule : bwdt_assertions

bind bwdt_top bwdt_assertions #(.RST_CYCLES(RST_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst),
   .load_valid(load_valid), .load_value(load_value), .act_nmi(act_nmi), .cold_rst(cold_rst),
   .nmi(nmi), .active(active), .expired(expired), .count(count));

// [dv/tb.sv]
// Purpose: self-checking bench for the board watchdog
// Assumes: shortened unit lengths
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
module tb;
   localparam int SEC = 10;
   localparam int MIN = 3;
   logic       clk        = 1'b0;
   logic       sys_rst    = 1'b1;
   logic       load_valid;
   logic [7:0] load_value;
   logic       unit_min;
   logic       act_nmi;
   logic       cold_rst;
   logic       nmi;
   logic       active;
   logic       expired;
   logic [7:0] count;
   int         n_mismatch = 0;
   int         checked    = 0;

   bwdt_top #(.SEC_CYCLES(SEC), .SECS_PER_MIN(MIN)) uut (.clk(clk), .sys_rst(sys_rst),
      .load_valid(load_valid), .load_value(load_value), .unit_min(unit_min), .act_nmi(act_nmi),
      .cold_rst(cold_rst), .nmi(nmi), .active(active), .expired(expired), .count(count));

   // 4 ns clock
   always #2 clk = ~clk;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   task automatic print_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // one-cycle load strobe, count seen one edge later
   task automatic load(input logic [7:0] v);
      @(negedge clk);
      load_valid = 1'b1;
      load_value = v;
      @(negedge clk);
      load_valid = 1'b0;
      chk("count", {8'h00, v}, {8'h00, count});
   endtask : load

   // load, run to expiry, judge timing and action
   task automatic t_expire(input logic [7:0] v, input logic um, input logic an);
      int n;
      int e;
      unit_min = um;
      act_nmi = an;
      load(v);
      e = v * SEC * (um ? MIN : 1) + 1;
      n = 0;
      while (expired !== 1'b1 && n < e + 4)
      begin
         @(negedge clk);
         n++;
      end
      chk("expiry time", 16'h0001, 16'(n + 2 >= e && n <= e + 2));
      if (n >= e + 4)
         print_verdict();
      chk("nmi", {15'h0000, an}, {15'h0000, nmi});
      chk("active", 16'h0000, {15'h0000, active});
      n = 0;
      while (cold_rst === 1'b1 && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      chk("strobe", an ? 16'h0000 : {8'h00, bwdt_pkg::RST_CYCLES}, 16'(n));
   endtask : t_expire

   // reload restarts, zero disables
   task automatic t_reload();
      unit_min = 1'b0;
      act_nmi = 1'b0;
      load(8'h03);
      repeat (25) @(negedge clk);
      chk("count run", 16'h0001, {8'h00, count});
      load(8'h07);
      load(8'h03);
      repeat (25) @(negedge clk);
      chk("count reload", 16'h0001, {8'h00, count});
      chk("expired", 16'h0000, {15'h0000, expired});
      load(8'h00);
      repeat (60) @(negedge clk);
      chk("disabled", 16'h0000, {13'h0000, cold_rst, nmi, active});
   endtask : t_reload

   // main sequence
   initial
   begin
      load_valid = 1'b0;
      load_value = 8'h00;
      unit_min = 1'b0;
      act_nmi = 1'b0;
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk("reset outputs", 16'h0000, {4'h0, cold_rst, nmi, active, expired, count});
      sys_rst = 1'b0;
      t_expire(8'h02, 1'b0, 1'b0);
      t_expire(8'h01, 1'b1, 1'b1);
      t_expire(8'hFF, 1'b0, 1'b1);
      t_reload();
      print_verdict();
   end
endmodule : tb
